// [core/bcc_cfg.svh]
`ifndef BCC_CFG_SVH
`define BCC_CFG_SVH

// Temperatures are signed, 0.1 degC per LSB; load factor in 0.01 percent units
`define BCC_TEMP_W 12
`define BCC_LF_W 16
`define BCC_LF_MAX 16'd10000
`define BCC_LF_ON 16'd5000
`define BCC_ON_BAND 12'sd10
`define BCC_OFF_BAND 12'sd40
// Gains in 0.1 units: proportional 2.0, integral 1.0, each 0..20
`define BCC_KP_RESET 8'd20
`define BCC_KI_RESET 8'd10
`define BCC_GAIN_MAX 8'd200
`define BCC_BIV_RESET -12'sd100
`define BCC_BIV_MIN -12'sd200
`define BCC_BIV_MAX 12'sd200
`define BCC_OFFSET_RESET 12'sd40
`define BCC_OFFSET_MAX 12'sd100
`define BCC_WAIT_RESET 7'd30
`define BCC_WAIT_MIN 7'd5
`define BCC_WAIT_MAX 7'd90
// Alternative hot-water target, chosen inside the 60..65 degC span
`define BCC_DHW_ALT_TARGET 12'sd620
`define BCC_DHW_ALT_MIN 12'sd600
`define BCC_DHW_ALT_MAX 12'sd650
// Ticks per minute for the waiting timer
`define BCC_TICKS_PER_MIN 16'd60

`endif

// [core/bcc_pkg.sv]
package bcc_pkg;

    typedef enum logic [1:0] {
        BCC_SRC_HP_ONLY,
        BCC_SRC_HP_HEATER,
        BCC_SRC_HP_BOILER,
        BCC_SRC_HP_HEATER_BOILER
    } bcc_source_t;

    typedef enum logic {
        BCC_MODE_PARALLEL,
        BCC_MODE_ALTERNATIVE
    } bcc_mode_t;

    typedef struct packed {
        bcc_source_t heat_source;
        bcc_mode_t mode;
        logic signed [11:0] boiler_bivalent_point;
        logic signed [11:0] supply_offset;
        logic [6:0] boiler_wait_time;
        logic [7:0] proportional_gain;
        logic [7:0] integral_gain;
        logic hot_water_by_boiler;
        logic tank_heater_enable;
        logic emergency_tank_heater_enable;
    } bcc_cfg_t;

    typedef struct packed {
        logic signed [11:0] outdoor_avg_temp;
        logic signed [11:0] separator_hot_water_temp;
        logic signed [11:0] max_target_outlet_temp;
        logic space_demand;
        logic dhw_demand;
        logic space_emergency;
        logic dhw_emergency;
        logic hp_block;
        logic low_ambient_startup;
        logic high_ambient;
        logic hp_running;
        logic heater_request;
    } bcc_plant_t;

endpackage

// [core/bcc_wait_timer.sv]
`timescale 1ns/10ps
`include "bcc_cfg.svh"

module bcc_wait_timer (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic hp_running,
    input wire logic [6:0] wait_min,
    output logic elapsed
);
    logic [15:0] sub_q, sub_d;
    logic [6:0] min_q, min_d;

    // Minutes counted since the heat pump started; cleared while it is off
    always_comb begin
        sub_d = sub_q;
        min_d = min_q;
        if (!hp_running) begin
            sub_d = 16'h0000;
            min_d = 7'h00;
        end else if (tick && min_q < 7'h7F) begin
            if (sub_q == `BCC_TICKS_PER_MIN - 16'd1) begin
                sub_d = 16'h0000;
                min_d = min_q + 7'h01;
            end else begin
                sub_d = sub_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sub_q <= 16'h0000;
            min_q <= 7'h00;
        end else begin
            sub_q <= sub_d;
            min_q <= min_d;
        end
    end

    // Strictly more than the waiting time
    assign elapsed = min_q > wait_min;
endmodule

// [core/bcc_pi.sv]
`timescale 1ns/10ps
`include "bcc_cfg.svh"

module bcc_pi (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic run,
    input wire logic signed [11:0] error,
    input wire logic [7:0] kp,
    input wire logic [7:0] ki,
    output logic [15:0] load
);
    logic signed [23:0] integ_q, integ_d;
    logic signed [23:0] sum;
    logic [15:0] load_q, load_d;

    // Error in 0.1 degC times gain in 0.1 gives 0.01 percent units
    always_comb begin
        integ_d = integ_q;
        sum = 24'sd0;
        load_d = load_q;
        if (!run) begin
            integ_d = 24'sd0;
            load_d = 16'h0000;
        end else if (tick) begin
            integ_d = integ_q + 24'(error * $signed({1'b0, ki})) / 24'sd60;
            // Anti-windup: integral held within the output span
            if (integ_d < 24'sd0) begin
                integ_d = 24'sd0;
            end else if (integ_d > 24'sd10000) begin
                integ_d = 24'sd10000;
            end
            sum = integ_d + 24'(error * $signed({1'b0, kp}));
            if (sum < 24'sd0) begin
                load_d = 16'h0000;
            end else if (sum > 24'sd10000) begin
                load_d = `BCC_LF_MAX;
            end else begin
                load_d = sum[15:0];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            integ_q <= 24'sd0;
            load_q <= 16'h0000;
        end else begin
            integ_q <= integ_d;
            load_q <= load_d;
        end
    end

    assign load = load_q;
endmodule

// [core/bcc_boiler_ctrl.sv]
`timescale 1ns/10ps
`include "bcc_cfg.svh"

// Contract
// - Boiler and electric heater never both on.
// - Boiler only with boiler in heat source.
// - Load factor from clamped P+I term.
// - Gains shared with heater, defaults 2.0/1.0.
// - On above 50% and water below target-1.
// - Off at 0% or water above target+4.
// - Space heating needs outdoor below bivalent point.
// - Parallel runs with heat pump; alternative replaces.
// - Parallel waits configured time after pump start.
// - Parallel space target is max minus offset.
// - Alternative space target is max outlet.
// - Space special cases force alternative, no bivalent.
// - Parallel hot water needs boiler hot-water setting.
// - Parallel hot water needs tank heater disabled.
// - Alternative serves hot water regardless of setting.
// - Parallel hot water target is max outlet.
// - Alternative hot water target within 60-65.
// - Hot water special cases force alternative.
// - Tank heater has priority in special cases.
// - Emergency hot water needs heater or emergency disabled.
// - High ambient with heater disabled serves hot water.
module bcc_boiler_ctrl (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic tick,
    input wire bcc_pkg::bcc_cfg_t cfg,
    input wire bcc_pkg::bcc_plant_t plant,
    output logic boiler_on,
    output logic heater_on,
    output logic hp_stop,
    output logic signed [11:0] boiler_target,
    output logic [15:0] load_factor
);
    import bcc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Configuration sanitising
    logic [7:0] kp, ki;
    logic signed [11:0] biv, offs;
    logic [6:0] wait_min;

    // Out-of-range settings fall back to the nearest limit
    always_comb begin
        kp = (cfg.proportional_gain > `BCC_GAIN_MAX) ? `BCC_GAIN_MAX
            : cfg.proportional_gain;
        ki = (cfg.integral_gain > `BCC_GAIN_MAX) ? `BCC_GAIN_MAX : cfg.integral_gain;
        biv = cfg.boiler_bivalent_point;
        if (biv < `BCC_BIV_MIN) begin
            biv = `BCC_BIV_MIN;
        end else if (biv > `BCC_BIV_MAX) begin
            biv = `BCC_BIV_MAX;
        end
        offs = cfg.supply_offset;
        if (offs < 12'sd0) begin
            offs = 12'sd0;
        end else if (offs > `BCC_OFFSET_MAX) begin
            offs = `BCC_OFFSET_MAX;
        end
        wait_min = cfg.boiler_wait_time;
        if (wait_min < `BCC_WAIT_MIN) begin
            wait_min = `BCC_WAIT_MIN;
        end else if (wait_min > `BCC_WAIT_MAX) begin
            wait_min = `BCC_WAIT_MAX;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decision of whether and how the boiler may run
    function automatic logic src_has_boiler(input bcc_source_t s);
        return (s == BCC_SRC_HP_BOILER) || (s == BCC_SRC_HP_HEATER_BOILER);
    endfunction

    logic wait_done;
    logic cold;
    logic sh_special, dhw_special, dhw_emerg_ok, dhw_high_ok;
    logic sh_allow, dhw_allow, dhw_special_allow;
    logic alt_eff, allow;
    logic signed [11:0] target;

    bcc_wait_timer u_wait (
        .ref_clk(ref_clk),
        .rst(rst),
        .tick(tick),
        .hp_running(plant.hp_running),
        .wait_min(wait_min),
        .elapsed(wait_done)
    );

    always_comb begin
        cold = plant.outdoor_avg_temp < biv;
        sh_special = plant.space_emergency || plant.hp_block
            || plant.low_ambient_startup;
        // Tank heater takes the hot-water load first when it is allowed to
        dhw_emerg_ok = plant.dhw_emergency
            && (!cfg.tank_heater_enable || !cfg.emergency_tank_heater_enable);
        dhw_high_ok = plant.high_ambient && !cfg.tank_heater_enable;
        dhw_special = dhw_emerg_ok || dhw_high_ok
            || (plant.hp_block && !cfg.tank_heater_enable);
        sh_allow = 1'b0;
        dhw_allow = 1'b0;
        dhw_special_allow = 1'b0;
        alt_eff = 1'b0;
        target = 12'sd0;
        if (plant.space_demand) begin
            if (sh_special) begin
                sh_allow = 1'b1;
                alt_eff = 1'b1;
            end else if (cfg.mode == BCC_MODE_ALTERNATIVE) begin
                sh_allow = cold;
                alt_eff = 1'b1;
            end else begin
                sh_allow = cold && wait_done;
            end
            target = alt_eff ? plant.max_target_outlet_temp
                : 12'(plant.max_target_outlet_temp - offs);
        end else if (plant.dhw_demand) begin
            if (dhw_special) begin
                dhw_special_allow = 1'b1;
                alt_eff = 1'b1;
            end else if (cfg.mode == BCC_MODE_ALTERNATIVE) begin
                dhw_allow = cold;
                alt_eff = 1'b1;
            end else begin
                dhw_allow = cold && wait_done && cfg.hot_water_by_boiler
                    && !cfg.tank_heater_enable;
            end
            target = alt_eff ? `BCC_DHW_ALT_TARGET
                : plant.max_target_outlet_temp;
        end
        allow = src_has_boiler(cfg.heat_source)
            && (sh_allow || dhw_allow || dhw_special_allow);
    end

    ////////////////////////////////////////////////////////////////////////
    // Load factor
    logic signed [11:0] err;
    logic [15:0] lf;

    assign err = 12'(target - plant.separator_hot_water_temp);

    bcc_pi u_pi (
        .ref_clk(ref_clk),
        .rst(rst),
        .tick(tick),
        .run(allow),
        .error(err),
        .kp(kp),
        .ki(ki),
        .load(lf)
    );

    ////////////////////////////////////////////////////////////////////////
    // On/off hysteresis of the boiler relay
    logic on_q, on_d;
    logic alt_q, alt_d;
    logic signed [11:0] tgt_q, tgt_d;
    logic on_cond, off_cond;

    always_comb begin
        on_cond = (lf > `BCC_LF_ON)
            && (plant.separator_hot_water_temp < 12'(target - `BCC_ON_BAND));
        off_cond = (lf == 16'h0000)
            || (plant.separator_hot_water_temp > 12'(target + `BCC_OFF_BAND));
        on_d = on_q;
        if (!allow || plant.heater_request) begin
            on_d = 1'b0;
        end else if (tick) begin
            // Off wins so a stale load factor cannot keep the relay closed
            if (off_cond) begin
                on_d = 1'b0;
            end else if (on_cond) begin
                on_d = 1'b1;
            end
        end
        alt_d = allow && alt_eff;
        tgt_d = target;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            on_q <= 1'b0;
            alt_q <= 1'b0;
            tgt_q <= 12'sd0;
        end else begin
            on_q <= on_d;
            alt_q <= alt_d;
            tgt_q <= tgt_d;
        end
    end

    // Heater output is granted only when the boiler relay is open
    assign heater_on = plant.heater_request && !on_q;
    assign boiler_on = on_q;
    assign hp_stop = alt_q && on_q;
    assign boiler_target = tgt_q;
    assign load_factor = lf;
endmodule

// [tb/bcc_boiler_ctrl_properties.sv]
`timescale 1ns/10ps
`include "bcc_cfg.svh"

module bcc_boiler_ctrl_properties (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic tick,
    input wire bcc_pkg::bcc_cfg_t cfg,
    input wire bcc_pkg::bcc_plant_t plant,
    input wire logic boiler_on,
    input wire logic heater_on,
    input wire logic hp_stop,
    input wire logic signed [11:0] boiler_target,
    input wire logic [15:0] load_factor
);
    import bcc_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    // Relay closing is two steps: open, then closed
    sequence s_rise;
        !boiler_on ##1 boiler_on;
    endsequence
    sequence s_off_next;
        ##1 !boiler_on;
    endsequence
    AST_EXCLUSIVE: assert property (!(boiler_on && heater_on))
        else $error("boiler and heater both on");
    AST_HEATER_WINS: assert property (plant.heater_request |-> s_off_next)
        else $error("boiler kept on against heater");
    AST_SOURCE: assert property (!cfg.heat_source[1] |-> s_off_next)
        else $error("boiler on without boiler source");
    AST_LF_CLAMP: assert property (load_factor <= `BCC_LF_MAX)
        else $error("load factor above full scale");
    AST_ON_CAUSE: assert property (s_rise |->
        $past(tick) && $past(load_factor) > `BCC_LF_ON)
        else $error("boiler closed without tick and load");
    AST_OFF_EMPTY: assert property (
        boiler_on && tick && load_factor == 16'h0 |-> s_off_next)
        else $error("boiler kept on at zero load");
    AST_OFF_HOT: assert property (boiler_on && tick &&
        plant.separator_hot_water_temp > boiler_target + `BCC_OFF_BAND |-> s_off_next)
        else $error("boiler kept on with hot separator");
    AST_BIVALENT: assert property (plant.space_demand && !plant.space_emergency &&
        !plant.hp_block && !plant.low_ambient_startup &&
        plant.outdoor_avg_temp >= cfg.boiler_bivalent_point |-> s_off_next)
        else $error("boiler on above bivalent point");
    AST_DHW_SETTING: assert property (!plant.space_demand && plant.dhw_demand &&
        cfg.mode == BCC_MODE_PARALLEL && !cfg.hot_water_by_boiler && !plant.dhw_emergency &&
        !plant.hp_block && !plant.high_ambient |-> s_off_next)
        else $error("parallel hot water without setting");
endmodule

// [tb/bcc_water_model.sv]
`timescale 1ns/10ps

module bcc_water_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic boiler_on,
    input wire logic load_en,
    input wire logic signed [11:0] load_val,
    output logic signed [11:0] water_q
);
    logic signed [11:0] water_d;
    ////////////////////////////////////////////////////////////////////////
    // Boiler heats the separator fast, losses cool it slowly, so hysteresis is seen
    always_comb begin
        water_d = water_q;
        if (rst) begin
            water_d = 12'sh0C8;
        end else if (load_en) begin
            water_d = load_val;
        end else if (tick) begin
            water_d = boiler_on ? water_q + 12'sh003 : water_q - 12'sh001;
        end
    end
    always_ff @(posedge ref_clk) begin
        water_q <= water_d;
    end
endmodule

// [tb/test_bcc_boiler_ctrl.sv]
`timescale 1ns/10ps
`include "bcc_cfg.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected at %0t: got %0h want %0h", $time, g, e); end end

module test_bcc_boiler_ctrl;
    import bcc_pkg::*;
    logic ref_clk;
    logic rst;
    logic tick;
    logic load_en;
    logic signed [11:0] load_val;
    logic signed [11:0] water;
    bcc_cfg_t cfg;
    bcc_plant_t ps;
    bcc_plant_t plant;
    logic boiler_on;
    logic heater_on;
    logic hp_stop;
    logic signed [11:0] boiler_target;
    logic [15:0] load_factor;
    int fail_count;
    int n_compared;
    ////////////////////////////////////////////////////////////////////////
    always #12.5 ref_clk = ~ref_clk;
    // Separator sensor comes from the water model, the rest from the bench
    always_comb begin
        plant = ps;
        plant.separator_hot_water_temp = water;
    end
    bcc_boiler_ctrl dut_u (.ref_clk(ref_clk), .rst(rst), .tick(tick), .cfg(cfg),
        .plant(plant), .boiler_on(boiler_on), .heater_on(heater_on), .hp_stop(hp_stop),
        .boiler_target(boiler_target), .load_factor(load_factor));
    bcc_water_model mdl_u (.ref_clk(ref_clk), .rst(rst), .tick(tick), .boiler_on(boiler_on),
        .load_en(load_en), .load_val(load_val), .water_q(water));
    // Back-to-back ticks; ends on an edge so callers may drive by NBA
    task tk(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            tick <= 1'b1;
        end
        @(posedge ref_clk);
        tick <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask
    task until_on(input logic v, input int lim);
        int i;
        i = 0;
        while (boiler_on !== v && i < lim) begin
            tk(1);
            i++;
        end
    endtask
    // Cold separator so only the rules under test decide
    task cold();
        @(posedge ref_clk);
        load_en <= 1'b1;
        @(posedge ref_clk);
        load_en <= 1'b0;
    endtask
    task stop_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Whole run is under 2000 cycles; the limit still covers every wait loop running out
    initial begin
        repeat (40000) @(posedge ref_clk);
        fail_count++;
        stop_test();
    end
    initial begin
        ref_clk = 1'b0;
        rst = 1'b1;
        tick = 1'b0;
        load_en = 1'b0;
        load_val = 12'sh0C8;
        fail_count = 0;
        n_compared = 0;
        cfg = '0;
        cfg.heat_source = BCC_SRC_HP_BOILER;
        cfg.boiler_bivalent_point = -12'sh064;
        cfg.supply_offset = 12'sh028;
        cfg.boiler_wait_time = 7'h05;
        cfg.proportional_gain = 8'h14;
        cfg.integral_gain = 8'h0A;
        ps = '0;
        ps.outdoor_avg_temp = -12'sh096;
        ps.max_target_outlet_temp = 12'sh1C2;
        ps.space_demand = 1'b1;
        ps.hp_running = 1'b1;
        repeat (5) @(posedge ref_clk);
        `CHK(boiler_on, 1'b0)
        `CHK(load_factor, 16'h0)
        rst <= 1'b0;
        $display("test reset done");
        tk(280);
        `CHK(boiler_on, 1'b0)
        `CHK(boiler_target, 12'sh19A)
        // Load is held empty while the boiler is not yet permitted
        `CHK(load_factor, 16'h0000)
        until_on(1'b1, 300);
        `CHK(boiler_on, 1'b1)
        `CHK(load_factor, `BCC_LF_MAX)
        `CHK(hp_stop, 1'b0)
        until_on(1'b0, 800);
        `CHK(boiler_on, 1'b0)
        $display("test parallel space done");
        cfg.mode <= BCC_MODE_ALTERNATIVE;
        cold();
        until_on(1'b1, 300);
        `CHK(boiler_target, 12'sh1C2)
        `CHK(hp_stop, 1'b1)
        ps.outdoor_avg_temp <= -12'sh032;
        tk(1);
        `CHK(boiler_on, 1'b0)
        ps.space_emergency <= 1'b1;
        cfg.mode <= BCC_MODE_PARALLEL;
        cold();
        until_on(1'b1, 300);
        `CHK(hp_stop, 1'b1)
        // Errors 25.0 then 25.1 degC at gains 2.0 and 1.0: P 50.20 plus I 0.82 percent
        `CHK(load_factor, 16'h13EE)
        // Hand the special case over between its three causes
        ps.space_emergency <= 1'b0;
        ps.hp_block <= 1'b1;
        tk(1);
        `CHK(boiler_on, 1'b1)
        ps.hp_block <= 1'b0;
        ps.low_ambient_startup <= 1'b1;
        tk(1);
        `CHK(boiler_on, 1'b1)
        ps.low_ambient_startup <= 1'b0;
        ps.space_emergency <= 1'b1;
        ps.heater_request <= 1'b1;
        tk(1);
        `CHK(boiler_on, 1'b0)
        `CHK(heater_on, 1'b1)
        ps.heater_request <= 1'b0;
        for (int s = 0; s < 2; s++) begin
            cfg.heat_source <= bcc_source_t'(s);
            tk(1);
            `CHK(boiler_on, 1'b0)
        end
        cfg.heat_source <= BCC_SRC_HP_HEATER_BOILER;
        cold();
        until_on(1'b1, 300);
        `CHK(boiler_on, 1'b1)
        $display("test special space done");
        ps.space_emergency <= 1'b0;
        ps.space_demand <= 1'b0;
        ps.dhw_demand <= 1'b1;
        ps.outdoor_avg_temp <= -12'sh096;
        tk(1);
        `CHK(boiler_on, 1'b0)
        cfg.hot_water_by_boiler <= 1'b1;
        cold();
        until_on(1'b1, 300);
        `CHK(boiler_target, 12'sh1C2)
        cfg.tank_heater_enable <= 1'b1;
        tk(1);
        `CHK(boiler_on, 1'b0)
        cfg.mode <= BCC_MODE_ALTERNATIVE;
        cfg.hot_water_by_boiler <= 1'b0;
        cfg.tank_heater_enable <= 1'b0;
        cold();
        until_on(1'b1, 300);
        `CHK(boiler_on, 1'b1)
        `CHK(boiler_target inside {[12'sh258:12'sh28A]}, 1'b1)
        cfg.mode <= BCC_MODE_PARALLEL;
        cfg.tank_heater_enable <= 1'b1;
        cfg.emergency_tank_heater_enable <= 1'b1;
        ps.dhw_emergency <= 1'b1;
        tk(1);
        `CHK(boiler_on, 1'b0)
        cfg.emergency_tank_heater_enable <= 1'b0;
        cold();
        until_on(1'b1, 300);
        `CHK(boiler_on, 1'b1)
        ps.dhw_emergency <= 1'b0;
        ps.high_ambient <= 1'b1;
        ps.outdoor_avg_temp <= 12'sh190;
        tk(1);
        `CHK(boiler_on, 1'b0)
        cfg.tank_heater_enable <= 1'b0;
        cold();
        until_on(1'b1, 300);
        `CHK(boiler_on, 1'b1)
        ps.high_ambient <= 1'b0;
        ps.hp_block <= 1'b1;
        tk(1);
        `CHK(boiler_on, 1'b1)
        $display("test hot water done");
        stop_test();
    end
endmodule

bind bcc_boiler_ctrl bcc_boiler_ctrl_properties chk_u (.ref_clk(ref_clk), .rst(rst),
    .tick(tick), .cfg(cfg), .plant(plant), .boiler_on(boiler_on), .heater_on(heater_on),
    .hp_stop(hp_stop), .boiler_target(boiler_target), .load_factor(load_factor));
